// [rtcpit_pkg.sv]
// Constants, register map and field layout for the periodic tick timer block.
// Assumes a 32-bit AXI4-Lite register bus and one system clock at 25 MHz.
// Summary of operation
// - sixteen-bit match value, read and written as separate low and high bytes.
// - compare flag sets when running count becomes equal to the match value.
// - interval field bits 6:3 picks 4 to 32768 RTC cycles; 0 means none.
// - control bit 0 enables the periodic timer; zero stops periodic events.
// - busy bit high while new control settings cross into the RTC domain.
// - enable bit gates the periodic interrupt request; one lets it through.
// - periodic flag sets each time the selected interval expires.
// - writing one clears the periodic flag; writing zero leaves it unchanged.
// - run bit zero with CPU halted stops the timer and ignores events.
// - run bit one keeps the timer counting while the CPU is halted.
package rtcpit_pkg;
    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_MATCH_LO = 6'h0C;
    localparam logic [5:0] IDX_MATCH_HI = 6'h0D;
    localparam logic [5:0] IDX_TICK_CONTROL = 6'h10;
    localparam logic [5:0] IDX_TICK_SYNC_STATUS = 6'h11;
    localparam logic [5:0] IDX_TICK_IRQ_ENABLE = 6'h12;
    localparam logic [5:0] IDX_TICK_IRQ_FLAGS = 6'h13;
    localparam logic [5:0] IDX_TICK_DEBUG_CONTROL = 6'h15;
    localparam int ADDR_W = 8;

    // field positions
    localparam int POS_TIMER_ON = 0;
    localparam int POS_PERIOD_LO = 3;
    localparam int POS_PERIOD_HI = 6;
    localparam int POS_TICK_IRQ = 0;
    localparam int POS_MATCH_IRQ = 1;
    localparam int POS_SYNCING = 0;
    localparam int POS_RUN_HALTED = 0;

    // reset values
    localparam logic [7:0] RST_TICK_CONTROL = 8'h00;
    localparam logic [1:0] RST_IRQ = 2'h0;
    localparam logic [15:0] RST_MATCH_VALUE = 16'h0000;

    // interval codes
    localparam logic [3:0] PERIOD_OFF = 4'h0;
    localparam logic [3:0] PERIOD_RESERVED = 4'hF;

    // settings cross into the RTC domain in two RTC clock cycles
    localparam logic [1:0] SYNC_RTC_CYCLES = 2'h2;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [3:0] period;
        logic timer_on;
    } rtcpit_cfg_t;

    typedef struct packed {
        logic match_hit;
        logic tick_hit;
    } rtcpit_irq_t;
endpackage

// [rtcpit_timer.sv]
// Periodic tick counter running on sampled RTC clock edges.
// Assumes rtc_edge is a one-cycle pulse per RTC clock cycle, synchronous to aclk.
`timescale 1ns/100ps
module rtcpit_timer (
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // control
    input wire logic rtc_edge,
    input wire logic freeze,
    input wire rtcpit_pkg::rtcpit_cfg_t cfg,
    // event
    output logic tick
);
    logic [14:0] count;
    logic [14:0] next_count;
    logic [15:0] span_mask;
    logic live;
    logic expire;

    assign live = cfg.timer_on && cfg.period != rtcpit_pkg::PERIOD_OFF && cfg.period != rtcpit_pkg::PERIOD_RESERVED;
    // code n spans 2^(n+1) cycles
    assign span_mask = 16'((17'h00001 << (5'(cfg.period) + 5'h01)) - 17'h00001);
    assign expire = &(count | ~span_mask[14:0]);
    assign next_count = expire ? 15'h0000 : 15'(count + 15'h0001);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= 15'h0000;
            tick <= 1'b0;
        end else if (ce) begin
            tick <= 1'b0;
            if (!live) begin
                count <= 15'h0000;
            end else if (rtc_edge && !freeze) begin
                count <= next_count;
                tick <= expire;
            end
        end
    end
endmodule // rtcpit_timer

// [rtcpit_top.sv]
// Periodic tick timer with match value, AXI4-Lite register slave and interrupt.
// Assumes rtc_clk, running_count and cpu_halted are synchronous to aclk.
`timescale 1ns/100ps
module rtcpit_top (
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // rtc side
    input wire logic rtc_clk,
    input wire logic [15:0] running_count,
    input wire logic cpu_halted,
    // interrupts
    output logic tick_irq_req,
    output logic irq
);
    // write channel holding
    logic aw_held;
    logic w_held;
    logic [5:0] aw_idx;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    // registers
    rtcpit_pkg::rtcpit_cfg_t cfg_sw;
    rtcpit_pkg::rtcpit_cfg_t cfg_rtc;
    rtcpit_pkg::rtcpit_irq_t irq_enable;
    rtcpit_pkg::rtcpit_irq_t irq_flags;
    logic [15:0] match_value;
    logic run_while_halted;
    logic [1:0] sync_left;
    logic rtc_q;
    logic match_q;
    logic [1:0] flag_bits;

    wire rtc_edge = rtc_clk && !rtc_q;
    wire tick_settings_syncing = sync_left != 2'h0;
    wire freeze = cpu_halted && !run_while_halted;
    wire do_write = aw_held && w_held && !s_axi_bvalid;
    wire wr_lane0 = do_write && w_strb[0];
    // write index decode
    wire aw_mlo = aw_idx == rtcpit_pkg::IDX_MATCH_LO;
    wire aw_mhi = aw_idx == rtcpit_pkg::IDX_MATCH_HI;
    wire aw_ctrl = aw_idx == rtcpit_pkg::IDX_TICK_CONTROL;
    wire aw_stat = aw_idx == rtcpit_pkg::IDX_TICK_SYNC_STATUS;
    wire aw_ien = aw_idx == rtcpit_pkg::IDX_TICK_IRQ_ENABLE;
    wire aw_flags = aw_idx == rtcpit_pkg::IDX_TICK_IRQ_FLAGS;
    wire aw_dbg = aw_idx == rtcpit_pkg::IDX_TICK_DEBUG_CONTROL;
    wire aw_hit = aw_mlo || aw_mhi || aw_ctrl || aw_stat || aw_ien || aw_flags || aw_dbg;
    wire wr_ctrl = wr_lane0 && aw_ctrl;
    wire wr_ien = wr_lane0 && aw_ien;
    wire wr_flags = wr_lane0 && aw_flags;
    wire wr_dbg = wr_lane0 && aw_dbg;
    wire wr_mlo = wr_lane0 && aw_mlo;
    wire wr_mhi = wr_lane0 && aw_mhi;
    wire [5:0] ar_idx = s_axi_araddr[7:2];
    wire take_ar = s_axi_arvalid && s_axi_arready && ce;
    wire tick;
    wire match_now = running_count == match_value;
    wire match_rise = match_now && !match_q && !freeze;
    wire [1:0] clear_mask = wr_flags ? w_data[1:0] : 2'h0;
    wire [1:0] set_mask = {match_rise, tick};
    wire [1:0] next_flags = (flag_bits & ~clear_mask) | set_mask;
    wire [7:0] ctrl_byte = {1'b0, cfg_sw.period, 2'b00, cfg_sw.timer_on};
    wire apply_cfg = ce && !wr_ctrl && tick_settings_syncing && rtc_edge && sync_left == 2'h1;

    // read decode
    logic [7:0] rd_byte;
    logic rd_hit;
    always_comb begin
        rd_byte = 8'h00;
        rd_hit = 1'b1;
        case (ar_idx)
            rtcpit_pkg::IDX_MATCH_LO: rd_byte = match_value[7:0];
            rtcpit_pkg::IDX_MATCH_HI: rd_byte = match_value[15:8];
            rtcpit_pkg::IDX_TICK_CONTROL: rd_byte = ctrl_byte;
            rtcpit_pkg::IDX_TICK_SYNC_STATUS: rd_byte = {7'h00, tick_settings_syncing};
            rtcpit_pkg::IDX_TICK_IRQ_ENABLE: rd_byte = {6'h00, irq_enable};
            rtcpit_pkg::IDX_TICK_IRQ_FLAGS: rd_byte = {6'h00, irq_flags};
            rtcpit_pkg::IDX_TICK_DEBUG_CONTROL: rd_byte = {7'h00, run_while_halted};
            default: rd_hit = 1'b0;
        endcase
    end

    // readies drop while ce is low so no beat is lost
    assign s_axi_awready = !aw_held && ce;
    assign s_axi_wready = !w_held && ce;
    assign s_axi_arready = !s_axi_rvalid && ce;

    // write address capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_idx <= 6'h00;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_idx <= s_axi_awaddr[7:2];
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
        end
    end

    // write data capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else if (ce) begin
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    // write response valid
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
        end else if (ce) begin
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // write response code, unmapped index refused
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bresp <= rtcpit_pkg::RESP_OKAY;
        end else if (ce && do_write) begin
            s_axi_bresp <= aw_hit ? rtcpit_pkg::RESP_OKAY : rtcpit_pkg::RESP_SLVERR;
        end
    end

    // read response valid
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
        end else if (ce) begin
            if (take_ar) begin
                s_axi_rvalid <= 1'b1;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // read data and code, held until taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= rtcpit_pkg::RESP_OKAY;
        end else if (take_ar) begin
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= rd_hit ? rtcpit_pkg::RESP_OKAY : rtcpit_pkg::RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_sw <= rtcpit_pkg::rtcpit_cfg_t'(5'h00);
        end else if (ce && wr_ctrl) begin
            cfg_sw.period <= w_data[rtcpit_pkg::POS_PERIOD_HI:rtcpit_pkg::POS_PERIOD_LO];
            cfg_sw.timer_on <= w_data[rtcpit_pkg::POS_TIMER_ON];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_enable <= rtcpit_pkg::RST_IRQ;
        end else if (ce && wr_ien) begin
            irq_enable <= w_data[1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_while_halted <= 1'b0;
        end else if (ce && wr_dbg) begin
            run_while_halted <= w_data[rtcpit_pkg::POS_RUN_HALTED];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            match_value[7:0] <= rtcpit_pkg::RST_MATCH_VALUE[7:0];
        end else if (ce && wr_mlo) begin
            match_value[7:0] <= w_data[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            match_value[15:8] <= rtcpit_pkg::RST_MATCH_VALUE[15:8];
        end else if (ce && wr_mhi) begin
            match_value[15:8] <= w_data[7:0];
        end
    end

    // rtc clock sample for edge detect
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rtc_q <= 1'b0;
        end else if (ce) begin
            rtc_q <= rtc_clk;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_left <= 2'h0;
        end else if (ce) begin
            if (wr_ctrl) begin
                sync_left <= rtcpit_pkg::SYNC_RTC_CYCLES;
            end else if (tick_settings_syncing && rtc_edge) begin
                sync_left <= 2'(sync_left - 2'h1);
            end
        end
    end

    // settings reach the rtc domain copy
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_rtc <= rtcpit_pkg::rtcpit_cfg_t'(5'h00);
        end else if (apply_cfg) begin
            cfg_rtc <= cfg_sw;
        end
    end

    // compare level sample for start detect
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            match_q <= 1'b0;
        end else if (ce) begin
            match_q <= match_now;
        end
    end

    for (genvar b = 0; b < 2; b++) begin : g_flag
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                flag_bits[b] <= rtcpit_pkg::RST_IRQ[b];
            end else if (ce) begin
                flag_bits[b] <= next_flags[b];
            end
        end
    end
    assign irq_flags = flag_bits;

    rtcpit_timer u_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .rtc_edge(rtc_edge),
        .freeze(freeze),
        .cfg(cfg_rtc),
        .tick(tick)
    );

    assign tick_irq_req = irq_flags.tick_hit && irq_enable.tick_hit;
    assign irq = |(irq_flags & irq_enable);
endmodule // rtcpit_top

// [rtcpit_sva.sv]
// Checker for rtcpit_top: bus handshakes and interrupt outputs.
// Assumes it is bound to rtcpit_top, with ce held high.
`timescale 1ns/100ps
module rtcpit_sva (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write channels
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read channels
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    // interrupts
    input wire logic tick_irq_req,
    input wire logic irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire logic mapped = s_axi_araddr[7:2] inside {6'h0C, 6'h0D, 6'h10, 6'h11, 6'h12, 6'h13, 6'h15};
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    AST_WR_RESP: assert property (wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer late");
    AST_RD_RESP: assert property (rd_taken |=> s_axi_rvalid) else $error("read answer late");
    AST_RD_UNMAPPED: assert property (s_axi_arvalid && s_axi_arready && !mapped |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("unmapped read answered wrongly");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    AST_B_AFTER_BOTH: assert property ($rose(s_axi_bvalid) |-> !$past(s_axi_awready) && !$past(s_axi_wready))
        else $error("write answered before address and data held");
    AST_REQ_IRQ: assert property (tick_irq_req |-> irq) else $error("request without irq");
    AST_TICK_FALL: assert property ($fell(tick_irq_req) |-> $rose(s_axi_bvalid)) else $error("req fell alone");
    AST_IRQ_FALL: assert property ($fell(irq) |-> $rose(s_axi_bvalid)) else $error("irq fell alone");
endmodule // rtcpit_sva

// [rtcpit_top_tb.sv]
// Self-checking bench for rtcpit_top: registers, compare, periodic tick, debug halt.
// Assumes rtc_clk is made here at a quarter of aclk; ce is held high.
`timescale 1ns/100ps
module rtcpit_top_tb;
    logic aclk = 1'h0, aresetn = 1'h0, ce = 1'h1, rtc_clk = 1'h0, cpu_halted = 1'h0, tprev = 1'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, mv;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rnd = 32'h00011827;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [15:0] running_count = 16'hFFFF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tick_irq_req, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int miscompares = 0, comparisons = 0, cyc = 0, last = 0, gap = 0;
    logic [5:0] reg_idx [7] = '{6'h0C, 6'h0D, 6'h10, 6'h11, 6'h12, 6'h13, 6'h15};
    rtcpit_top u_rtcpit_top (.*);
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // aclk cycles between ticks, rtc period is four aclk
    function automatic int tick_gap(input logic [3:0] c);
        return 4 << (c + 4'h1);
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic final_report;
        if (miscompares == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial forever #20 aclk = ~aclk;
    // rtc clock, tick spacing and hang limit
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        rtc_clk <= cyc[1];
        tprev <= tick_irq_req;
        if (tick_irq_req && !tprev) begin
            gap <= cyc - last;
            last <= cyc;
        end
        if (cyc == 20000) begin
            miscompares++;
            final_report();
        end
    end
    task automatic wr(input logic [5:0] i, input logic [7:0] d, input logic [1:0] er);
        logic a, w, ta, tw;
        a = 1'h1;
        w = 1'h1;
        @(posedge aclk);
        rnd = lfsr(rnd);
        s_axi_awaddr <= {i, 2'h0};
        s_axi_wdata <= {rnd[31:8], d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (a || w) begin
            @(negedge aclk);
            ta = a && s_axi_awready;
            tw = w && s_axi_wready;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'h0;
            if (tw) s_axi_wvalid <= 1'h0;
            a = a && !ta;
            w = w && !tw;
        end
        @(negedge aclk);
        while (!s_axi_bvalid) @(negedge aclk);
        chk("bresp", s_axi_bresp, er);
        @(posedge aclk);
        s_axi_bready <= 1'h0;
    endtask
    task automatic rc(input string nm, input logic [5:0] i, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= {i, 2'h0};
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        @(negedge aclk);
        while (!s_axi_arready) @(negedge aclk);
        @(posedge aclk);
        s_axi_arvalid <= 1'h0;
        @(negedge aclk);
        while (!s_axi_rvalid) @(negedge aclk);
        chk(nm, s_axi_rdata, e);
        chk("rresp", s_axi_rresp, er);
        @(posedge aclk);
        s_axi_rready <= 1'h0;
    endtask
    task automatic wait_tick;
        @(negedge aclk);
        while (!tick_irq_req) @(negedge aclk);
        chk("irq_tick", irq, 1'h1);
        wr(6'h13, 8'h01, 2'h0);
    endtask
    task automatic quiet(input logic [7:0] c);
        wr(6'h10, c, 2'h0);
        repeat (40) @(posedge aclk);
        wr(6'h13, 8'h03, 2'h0);
        repeat (300) @(posedge aclk);
        rc("no_tick", 6'h13, 32'h0, 2'h0);
    endtask
    task automatic period(input logic [3:0] c);
        wr(6'h10, 8'h00, 2'h0);
        wr(6'h10, {1'h0, c, 3'h1}, 2'h0);
        rc("busy", 6'h11, 32'h1, 2'h0);
        repeat (3) wait_tick();
        chk("gap", gap, tick_gap(c));
        rc("idle", 6'h11, 32'h0, 2'h0);
    endtask
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        foreach (reg_idx[k]) rc("reset", reg_idx[k], 32'h0, 2'h0);
        rc("unmapped", 6'h3F, 32'h0, 2'h2);
        wr(6'h3F, 8'hFF, 2'h2);
        wr(6'h10, 8'hFF, 2'h0);
        rc("control", 6'h10, 32'h79, 2'h0);
        rnd = lfsr(rnd);
        mv = rnd[7:0];
        wr(6'h0C, mv, 2'h0);
        wr(6'h0D, ~mv, 2'h0);
        rc("match_lo", 6'h0C, {24'h0, mv}, 2'h0);
        rc("match_hi", 6'h0D, {24'h0, ~mv}, 2'h0);
        // compare event, reserved code gives no tick
        wr(6'h12, 8'h03, 2'h0);
        running_count <= {~mv, mv};
        repeat (4) @(posedge aclk);
        rc("cmp_flag", 6'h13, 32'h2, 2'h0);
        wr(6'h13, 8'h00, 2'h0);
        rc("keep_flag", 6'h13, 32'h2, 2'h0);
        wr(6'h13, 8'h02, 2'h0);
        rc("clr_flag", 6'h13, 32'h0, 2'h0);
        running_count <= 16'hFFFF;
        quiet(8'h79);
        quiet(8'h01);
        quiet(8'h08);
        cpu_halted <= 1'h1;
        quiet(8'h09);
        wr(6'h15, 8'h01, 2'h0);
        rc("dbg_run", 6'h15, 32'h1, 2'h0);
        period(4'h1);
        cpu_halted <= 1'h0;
        for (int c = 2; c < 5; c++) period(c[3:0]);
        period(4'h1 + {2'h0, rnd[9:8]});
        // enable bits gate the request and irq, not the flag
        wr(6'h12, 8'h00, 2'h0);
        repeat (300) @(posedge aclk);
        chk("req_gated", tick_irq_req, 1'h0);
        chk("irq_gated", irq, 1'h0);
        rc("flag_set", 6'h13, 32'h1, 2'h0);
        final_report();
    end
endmodule // rtcpit_top_tb
bind rtcpit_top rtcpit_sva u_rtcpit_sva (.*);
